// File: src/ubp_defines.vh
`ifndef UBP_DEFINES_VH
`define UBP_DEFINES_VH
// ==========================================
// clock and timing
`define UBP_CLK_PERIOD_NS 10
`define UBP_TICK_US 5000
`define UBP_TMAX_S 1800
`define UBP_TMAX_TICKS (`UBP_TMAX_S*1000000/`UBP_TICK_US)
// ==========================================
// register offsets
`define UBP_REG_CTRL 8'h00
`define UBP_REG_MINLOAD 8'h04
`define UBP_REG_DELAY 8'h08
`define UBP_REG_KMULT 8'h0C
`define UBP_REG_GSEL 8'h10
`define UBP_REG_NEGSET 8'h14
`define UBP_REG_RATSET 8'h18
`define UBP_REG_STATUS 8'h20
`define UBP_REG_RATIO 8'h24
`define UBP_REG_MSET 8'h28
`define UBP_REG_EXPECT 8'h2C
`define UBP_REG_REMAIN 8'h30
`define UBP_REG_REC_ANG 8'h34
`define UBP_REG_REC_ZERO 8'h38
// ==========================================
// control fields
`define UBP_CTRL_MODE 0
`define UBP_CTRL_FORCE_LO 1
`define UBP_CTRL_FORCE_EN 3
`define UBP_CTRL_DLY_LO 4
`define UBP_CTRL_GRP_LO 6
// ==========================================
// conditions and delay types
`define UBP_COND_NORMAL 2'h0
`define UBP_COND_START 2'h1
`define UBP_COND_TRIP 2'h2
`define UBP_COND_BLOCKED 2'h3
`define UBP_DLY_INSTANT 2'h0
`define UBP_DLY_DEFINITE 2'h1
`define UBP_DLY_QUAD 2'h2
// ==========================================
// settings, limits and reset values
`define UBP_NEGSET_MIN 16'h0001
`define UBP_NEGSET_MAX 16'h0FA0
`define UBP_NEGSET_RST 16'h0014
`define UBP_RATSET_MIN 16'h0064
`define UBP_RATSET_MAX 16'h4E20
`define UBP_RATSET_RST 16'h07D0
`define UBP_RESET_PCT 40'h0000000061
`define UBP_FULL_PCT 40'h0000000064
`define UBP_RATIO_SCALE 32'h00002710
`define UBP_MSET_SCALE 32'h00000064
`define UBP_RATIO_MAX 32'h3B9ACA00
`define UBP_MSET_MAX 32'h00989680
`define UBP_MINLOAD_RST 16'h000A
`define UBP_DELAY_RST 19'h00014
`define UBP_KMULT_RST 32'h00002710
`endif

// File: src/ubp_stage.v
// Our own choices: the strobed register port and the address map.
`include "ubp_defines.vh"
module ubp_stage #(
	parameter TICK_CYC = `UBP_TICK_US * 1000 / `UBP_CLK_PERIOD_NS,
	parameter NGRP = 8,
	parameter MW = 16
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// measurement front end, same clock
	input wire [MW-1:0] positive_seq_current,
	input wire [MW-1:0] negative_seq_current,
	input wire [MW-1:0] zero_seq_current,
	input wire [15:0] positive_seq_angle,
	input wire [15:0] negative_seq_angle,
	input wire [15:0] zero_seq_angle,
	input wire [MW-1:0] phase_a_fundamental,
	input wire [MW-1:0] phase_b_fundamental,
	input wire [MW-1:0] phase_c_fundamental,
	// blocking matrix pin
	input wire block_in,
	// status outputs
	output reg [1:0] condition,
	output reg start_out,
	output reg trip_out,
	output reg blocked_out
);
	localparam ST_NORMAL = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_TRIP = 2'h2;
	localparam ST_BLOCKED = 2'h3;
	localparam [31:0] TMAX_W = `UBP_TMAX_TICKS;
	localparam [18:0] TMAX = TMAX_W[18:0];

	// clamp a written setting into its legal range
	function [15:0] clampw;
		input [31:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			if (v < {16'h0000, lo})
				clampw = lo;
			else if (v > {16'h0000, hi})
				clampw = hi;
			else
				clampw = v[15:0];
		end
	endfunction

	// saturate a quotient to a ceiling
	function [31:0] sat;
		input [31:0] v;
		input [31:0] hi;
		begin
			sat = (v > hi) ? hi : v;
		end
	endfunction

	// ==========================================
	// settings
	reg mode_reg;
	reg [1:0] force_reg;
	reg force_en_reg;
	reg [1:0] dly_reg;
	reg [2:0] grp_reg;
	reg [2:0] gsel_reg;
	reg [15:0] minload_reg;
	reg [18:0] delay_reg;
	reg [31:0] kmult_reg;
	reg [15:0] negset_mem [0:NGRP-1];
	reg [15:0] ratset_mem [0:NGRP-1];
	integer i;

	// mode, force, delay type live outside the groups
	always @(posedge mclk) begin
		if (rst) begin
			mode_reg <= 1'b0;
			force_reg <= `UBP_COND_NORMAL;
			force_en_reg <= 1'b0;
			dly_reg <= `UBP_DLY_DEFINITE;
			grp_reg <= 3'h0;
			gsel_reg <= 3'h0;
			minload_reg <= `UBP_MINLOAD_RST;
			delay_reg <= `UBP_DELAY_RST;
			kmult_reg <= `UBP_KMULT_RST;
			for (i = 0; i < NGRP; i = i + 1) begin
				negset_mem[i] <= `UBP_NEGSET_RST;
				ratset_mem[i] <= `UBP_RATSET_RST;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				`UBP_REG_CTRL: begin
					mode_reg <= reg_wdata[`UBP_CTRL_MODE];
					force_reg <= reg_wdata[`UBP_CTRL_FORCE_LO+:2];
					force_en_reg <= reg_wdata[`UBP_CTRL_FORCE_EN];
					dly_reg <= reg_wdata[`UBP_CTRL_DLY_LO+:2];
					grp_reg <= reg_wdata[`UBP_CTRL_GRP_LO+:3];
				end
				`UBP_REG_MINLOAD: minload_reg <= reg_wdata[15:0];
				`UBP_REG_DELAY: delay_reg <= (reg_wdata > {13'h0, TMAX}) ? TMAX : reg_wdata[18:0];
				`UBP_REG_KMULT: kmult_reg <= reg_wdata;
				`UBP_REG_GSEL: gsel_reg <= reg_wdata[2:0];
				`UBP_REG_NEGSET: negset_mem[gsel_reg] <=
					clampw(reg_wdata, `UBP_NEGSET_MIN, `UBP_NEGSET_MAX);
				`UBP_REG_RATSET: ratset_mem[gsel_reg] <=
					clampw(reg_wdata, `UBP_RATSET_MIN, `UBP_RATSET_MAX);
				default: ;
			endcase
		end
	end

	// active group read live, so a group switch takes hold next cycle
	wire [15:0] negset = negset_mem[grp_reg];
	wire [15:0] ratset = ratset_mem[grp_reg];

	// ==========================================
	// program cycle divider and block synchroniser
	reg [31:0] tick_cnt_reg;
	reg tick_reg;
	reg blk_meta_reg;
	reg blk_sync_reg;
	reg blk_reg;

	always @(posedge mclk) begin
		if (rst) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == TICK_CYC - 1) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
			tick_reg <= 1'b0;
		end
	end

	// block from another domain: two flops, then one sample per cycle
	always @(posedge mclk) begin
		if (rst) begin
			blk_meta_reg <= 1'b0;
			blk_sync_reg <= 1'b0;
			blk_reg <= 1'b0;
		end else begin
			blk_meta_reg <= block_in;
			blk_sync_reg <= blk_meta_reg;
			if (tick_reg)
				blk_reg <= blk_sync_reg;
		end
	end

	// ==========================================
	// measurement sampling
	reg [MW-1:0] pos_reg;
	reg [MW-1:0] neg_reg;
	reg ld_ok_reg;

	always @(posedge mclk) begin
		if (rst) begin
			pos_reg <= {MW{1'b0}};
			neg_reg <= {MW{1'b0}};
			ld_ok_reg <= 1'b0;
		end else if (tick_reg) begin
			pos_reg <= positive_seq_current;
			neg_reg <= negative_seq_current;
			ld_ok_reg <= (phase_a_fundamental >= minload_reg) &&
				(phase_b_fundamental >= minload_reg) &&
				(phase_c_fundamental >= minload_reg);
		end
	end

	// ==========================================
	// shared serial divider: ratio, measured/set, curve time
	reg [1:0] dop_reg;
	reg [5:0] dcnt_reg;
	reg dbusy_reg;
	reg [31:0] dq_reg;
	reg [32:0] dr_reg;
	reg [31:0] dden_reg;
	reg [31:0] ratio_reg;
	reg [31:0] mset_reg;
	reg [31:0] quad_reg;
	wire [31:0] neg_sq = {16'h0, neg_reg} * {16'h0, neg_reg};
	wire [31:0] set_sq = {16'h0, negset} * {16'h0, negset};
	wire [32:0] dr_sh = {dr_reg[31:0], dq_reg[31]};
	wire dfit = dr_sh >= {1'b0, dden_reg};
	reg [31:0] dnum;
	reg [31:0] dden;

	// operands per step; negative-or-zero square gap gives zero divisor
	always @* begin
		case (dop_reg)
			2'h0: begin
				dnum = {16'h0, neg_reg} * `UBP_RATIO_SCALE;
				dden = {16'h0, pos_reg};
			end
			2'h1: begin
				dnum = {16'h0, neg_reg} * `UBP_MSET_SCALE;
				dden = {16'h0, negset};
			end
			default: begin
				dnum = kmult_reg;
				dden = (neg_sq > set_sq) ? neg_sq - set_sq : 32'h0;
			end
		endcase
	end

	// restoring division, 32 steps; zero divisor gives zero ratio, saturated curve time
	always @(posedge mclk) begin
		if (rst) begin
			dop_reg <= 2'h0;
			dcnt_reg <= 6'h0;
			dbusy_reg <= 1'b0;
			dq_reg <= 32'h0;
			dr_reg <= 33'h0;
			dden_reg <= 32'h0;
			ratio_reg <= 32'h0;
			mset_reg <= 32'h0;
			quad_reg <= 32'hFFFFFFFF;
		end else if (tick_reg) begin
			dop_reg <= 2'h0;
			dcnt_reg <= 6'h0;
			dbusy_reg <= 1'b0;
		end else if (!dbusy_reg && dop_reg != 2'h3) begin
			dbusy_reg <= 1'b1;
			dq_reg <= dnum;
			dr_reg <= 33'h0;
			dden_reg <= dden;
		end else if (dbusy_reg && dcnt_reg != 6'h20) begin
			dcnt_reg <= dcnt_reg + 6'h1;
			dr_reg <= dfit ? dr_sh - {1'b0, dden_reg} : dr_sh;
			dq_reg <= {dq_reg[30:0], dfit};
		end else if (dbusy_reg) begin
			case (dop_reg)
				2'h0: ratio_reg <= (dden_reg == 32'h0) ? 32'h0 : sat(dq_reg, `UBP_RATIO_MAX);
				2'h1: mset_reg <= sat(dq_reg, `UBP_MSET_MAX);
				default: quad_reg <= (dden_reg == 32'h0) ? 32'hFFFFFFFF : dq_reg;
			endcase
			dop_reg <= dop_reg + 2'h1;
			dcnt_reg <= 6'h0;
			dbusy_reg <= 1'b0;
		end
	end
	// one idle cycle between steps lets the operand mux follow the new dop_reg
	// before the load; three steps of 34 cycles fit well inside one tick

	// ==========================================
	// pick-up with fixed 97 percent release
	reg pick_reg;
	wire [31:0] mon = mode_reg ? ratio_reg : {16'h0, neg_reg};
	wire [31:0] setv = mode_reg ? {16'h0, ratset} : {16'h0, negset};
	wire ratio_ok = (pos_reg != {MW{1'b0}}) && ld_ok_reg;
	wire above = mon > setv;
	wire below = ({8'h0, mon} * `UBP_FULL_PCT) < ({8'h0, setv} * `UBP_RESET_PCT);

	always @(posedge mclk) begin
		if (rst)
			pick_reg <= 1'b0;
		else if (tick_reg) begin
			if (mode_reg && !ratio_ok)
				pick_reg <= 1'b0;
			else if (!pick_reg)
				pick_reg <= above;
			else
				pick_reg <= !below;
		end
	end

	// ==========================================
	// operating time and condition machine
	reg [1:0] st_reg;
	reg [1:0] st_next;
	reg [18:0] elapsed_reg;
	reg [18:0] expect_reg;
	reg [15:0] rec_zero_reg;
	reg [15:0] rec_pang_reg;
	reg [15:0] rec_nang_reg;
	reg [15:0] rec_zang_reg;
	wire [18:0] quad_t = (quad_reg > {13'h0, TMAX}) ? TMAX : quad_reg[18:0];
	wire [19:0] remain = {1'b0, expect_reg} - {1'b0, elapsed_reg};
	reg [18:0] expect_next;

	// expected time per delay type
	always @* begin
		case (dly_reg)
			`UBP_DLY_INSTANT: expect_next = 19'h0;
			`UBP_DLY_DEFINITE: expect_next = delay_reg;
			default: expect_next = quad_t;
		endcase
	end

	// block is only looked at once per cycle, hence the 5 ms lead
	always @* begin
		st_next = st_reg;
		case (st_reg)
			ST_NORMAL: begin
				if (pick_reg && blk_reg)
					st_next = ST_BLOCKED;
				else if (pick_reg)
					st_next = (expect_next == 19'h0) ? ST_TRIP : ST_START;
			end
			ST_START: begin
				if (!pick_reg)
					st_next = ST_NORMAL;
				else if (blk_reg)
					st_next = ST_BLOCKED;
				else if (elapsed_reg + 19'h1 >= expect_next)
					st_next = ST_TRIP;
			end
			ST_TRIP: begin
				if (!pick_reg)
					st_next = ST_NORMAL;
			end
			ST_BLOCKED: begin
				if (!pick_reg)
					st_next = ST_NORMAL;
			end
			default: st_next = ST_NORMAL;
		endcase
	end

	always @(posedge mclk) begin
		if (rst) begin
			st_reg <= ST_NORMAL;
			elapsed_reg <= 19'h0;
			expect_reg <= 19'h0;
			rec_zero_reg <= 16'h0;
			rec_pang_reg <= 16'h0;
			rec_nang_reg <= 16'h0;
			rec_zang_reg <= 16'h0;
		end else if (tick_reg) begin
			st_reg <= st_next;
			expect_reg <= expect_next;
			// timer restarts on any leave of start except to trip, where it holds
			if (st_next == ST_START)
				elapsed_reg <= (st_reg == ST_START) ? elapsed_reg + 19'h1 : 19'h0;
			else if (st_next != ST_TRIP)
				elapsed_reg <= 19'h0;
			// fault record snapshot; kept out of the decision path
			if (st_reg == ST_NORMAL && st_next != ST_NORMAL) begin
				rec_zero_reg <= zero_seq_current;
				rec_pang_reg <= positive_seq_angle;
				rec_nang_reg <= negative_seq_angle;
				rec_zang_reg <= zero_seq_angle;
			end
		end
	end

	// outputs, force only counts with global forcing enabled
	wire [1:0] cond_eff = force_en_reg ? force_reg : st_reg;
	always @(posedge mclk) begin
		if (rst) begin
			condition <= `UBP_COND_NORMAL;
			start_out <= 1'b0;
			trip_out <= 1'b0;
			blocked_out <= 1'b0;
		end else begin
			condition <= cond_eff;
			start_out <= (cond_eff == `UBP_COND_START) || (cond_eff == `UBP_COND_TRIP);
			trip_out <= cond_eff == `UBP_COND_TRIP;
			blocked_out <= cond_eff == `UBP_COND_BLOCKED;
		end
	end

	// ==========================================
	// register read, unmapped reads zero
	always @(posedge mclk) begin
		if (rst)
			reg_rdata <= 32'h0;
		else if (reg_rd) begin
			case (reg_addr)
				`UBP_REG_CTRL: reg_rdata <= {23'h0, grp_reg, dly_reg, force_en_reg,
					force_reg, mode_reg};
				`UBP_REG_MINLOAD: reg_rdata <= {16'h0, minload_reg};
				`UBP_REG_DELAY: reg_rdata <= {13'h0, delay_reg};
				`UBP_REG_KMULT: reg_rdata <= kmult_reg;
				`UBP_REG_GSEL: reg_rdata <= {29'h0, gsel_reg};
				`UBP_REG_NEGSET: reg_rdata <= {16'h0, negset_mem[gsel_reg]};
				`UBP_REG_RATSET: reg_rdata <= {16'h0, ratset_mem[gsel_reg]};
				`UBP_REG_STATUS: reg_rdata <= {28'h0, blk_reg, pick_reg, cond_eff};
				`UBP_REG_RATIO: reg_rdata <= ratio_reg;
				`UBP_REG_MSET: reg_rdata <= mset_reg;
				`UBP_REG_EXPECT: reg_rdata <= {13'h0, expect_reg};
				`UBP_REG_REMAIN: reg_rdata <= {{12{remain[19]}}, remain};
				`UBP_REG_REC_ANG: reg_rdata <= {rec_nang_reg, rec_pang_reg};
				`UBP_REG_REC_ZERO: reg_rdata <= {rec_zang_reg, rec_zero_reg};
				default: reg_rdata <= 32'h0;
			endcase
		end
	end
endmodule // ubp_stage

// File: bench/ubp_stage_asserts.sv
`include "ubp_defines.vh"
module ubp_stage_asserts #(
	parameter TICK_CYC = 200
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// block pin and status
	input wire block_in,
	input wire [1:0] condition,
	input wire start_out,
	input wire trip_out,
	input wire blocked_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BLK_LAG = 3 * TICK_CYC + 8;
	logic frc_q;
	logic [1:0] fval_q;
	logic [1:0] dly_q;
	logic [1:0] fcnt;
	logic [31:0] blk_age;
	// ========
	// shadow of control; fcnt masks the settle after a write
	always_ff @(posedge mclk) begin
		if (rst) begin
			frc_q <= 1'b0;
			fval_q <= 2'h0;
			dly_q <= `UBP_DLY_DEFINITE;
			fcnt <= 2'h3;
		end else if (reg_wr && reg_addr == `UBP_REG_CTRL) begin
			frc_q <= reg_wdata[3];
			fval_q <= reg_wdata[2:1];
			dly_q <= reg_wdata[5:4];
			fcnt <= 2'h0;
		end else if (fcnt != 2'h3) begin
			fcnt <= fcnt + 2'h1;
		end
	end
	// cycles since the block pin was last high
	always_ff @(posedge mclk) begin
		if (rst || block_in) begin
			blk_age <= rst ? 32'hFFFFFFFF : 32'h0;
		end else if (blk_age != 32'hFFFFFFFF) begin
			blk_age <= blk_age + 32'h1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ========
	// properties
	property p_rst_idle;
		$fell(rst) |-> condition == 2'h0 && !start_out && !trip_out && !blocked_out;
	endproperty
	property p_start_map;
		!frc_q && fcnt == 2'h3 |-> start_out == (condition == 2'h1 || condition == 2'h2);
	endproperty
	property p_trip_map;
		!frc_q && fcnt == 2'h3 |-> trip_out == (condition == `UBP_COND_TRIP);
	endproperty
	property p_blk_map;
		!frc_q && fcnt == 2'h3 |-> blocked_out == (condition == `UBP_COND_BLOCKED);
	endproperty
	property p_rd_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	property p_unmapped;
		reg_rd && reg_addr == 8'h3C |=> reg_rdata == 32'h0;
	endproperty
	property p_force;
		frc_q && fcnt == 2'h3 |-> condition == fval_q;
	endproperty
	// a blocked report needs a recent block on the pin
	property p_blk_cause;
		$rose(blocked_out) && !frc_q && fcnt == 2'h3 |-> blk_age < BLK_LAG;
	endproperty
	property p_trip_order;
		$rose(trip_out) && !frc_q && fcnt == 2'h3 && dly_q != `UBP_DLY_INSTANT
			|-> $past(condition) == `UBP_COND_START;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("status not idle after reset");
	a_start_map: assert property (p_start_map) else $error("start out of step");
	a_trip_map: assert property (p_trip_map) else $error("trip out of step");
	a_blk_map: assert property (p_blk_map) else $error("blocked out of step");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_unmapped: assert property (p_unmapped) else $error("hole read not zero");
	a_force: assert property (p_force) else $error("forced status missed");
	a_blk_cause: assert property (p_blk_cause) else $error("blocked without block");
	a_trip_order: assert property (p_trip_order) else $error("trip skipped start");
	c_start: cover property ($rose(start_out));
	c_trip: cover property ($rose(trip_out));
	c_block: cover property ($rose(blocked_out));
	c_force: cover property (frc_q && fcnt == 2'h3);
endmodule // ubp_stage_asserts
bind ubp_stage ubp_stage_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.*);

// File: bench/ubp_front_model.sv
module ubp_front_model (
	// clock
	input wire mclk,
	// sequence magnitudes and angles
	output logic [15:0] pos_mag,
	output logic [15:0] neg_mag,
	output logic [15:0] zero_mag,
	output logic [15:0] pos_ang,
	output logic [15:0] neg_ang,
	output logic [15:0] zero_ang,
	// phase fundamentals
	output logic [15:0] ph_a,
	output logic [15:0] ph_b,
	output logic [15:0] ph_c,
	// blocking matrix
	output logic blk
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// record-only values, held steady so snapshots are predictable
	assign zero_mag = 16'h0005;
	assign pos_ang = 16'h1111;
	assign neg_ang = 16'h3333;
	assign zero_ang = 16'h2222;
	initial begin
		{pos_mag, neg_mag, ph_a, ph_b, ph_c, blk} = '0;
	end
	// magnitudes computed upstream, launched after an edge
	task put(input logic [15:0] p, n, a, c);
		@(posedge mclk);
		pos_mag <= p;
		neg_mag <= n;
		ph_a <= a;
		ph_b <= a;
		ph_c <= c;
	endtask
	// callers keep a block at least one tick ahead of delay expiry
	task set_blk(input logic b);
		@(posedge mclk);
		blk <= b;
	endtask
endmodule // ubp_front_model

// File: bench/ubp_stage_test.sv
`include "ubp_defines.vh"
module ubp_stage_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 200;
	logic mclk, rst, reg_wr, reg_rd, blk;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [15:0] pm, nm, zm, pa, na, za, fa, fb, fc;
	logic [1:0] condition;
	logic start_out, trip_out, blocked_out;
	int errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int k;
	logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h3C};
	logic [31:0] re[7] = '{32'h10, 32'hA, 32'h14, 32'h2710, 32'h14, 32'h7D0, 32'h0};
	logic [7:0] ca[4] = '{8'h14, 8'h14, 8'h18, 8'h18};
	logic [31:0] cw[4] = '{32'h0, 32'hFFFF, 32'h0, 32'hFFFF};
	logic [31:0] ce[4] = '{32'h1, 32'hFA0, 32'h64, 32'h4E20};
	ubp_stage #(.TICK_CYC(TC)) dut (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.positive_seq_current(pm), .negative_seq_current(nm), .zero_seq_current(zm),
		.positive_seq_angle(pa), .negative_seq_angle(na), .zero_seq_angle(za),
		.phase_a_fundamental(fa), .phase_b_fundamental(fb), .phase_c_fundamental(fc),
		.block_in(blk), .condition(condition), .start_out(start_out),
		.trip_out(trip_out), .blocked_out(blocked_out)
	);
	ubp_front_model fe (
		.mclk(mclk), .pos_mag(pm), .neg_mag(nm), .zero_mag(zm), .pos_ang(pa),
		.neg_ang(na), .zero_ang(za), .ph_a(fa), .ph_b(fb), .ph_c(fc), .blk(blk)
	);
	// ========
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			finish_test();
		end
	end
	// ========
	// access and compare tasks
	task finish_test;
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// data stands from the cycle after the strobe until the next read
	task rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task tk(input int n);
		repeat (n * TC) @(posedge mclk);
		#1;
	endtask
	task wc(input logic [1:0] c, input int n);
		k = 0;
		while (condition !== c && k < n * TC) begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk(condition, c);
	endtask
	task pn(input logic [15:0] n);
		fe.put(16'h03E8, n, 16'h03E8, 16'h03E8);
	endtask
	// ========
	// main sequence
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		rst = 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		foreach (ra[i]) rc(ra[i], re[i]);
		foreach (ca[i]) begin
			wr(ca[i], cw[i]);
			rc(ca[i], ce[i]);
		end
		wr(`UBP_REG_NEGSET, 32'h64);
		wr(`UBP_REG_RATSET, 32'h7D0);
		wr(`UBP_REG_DELAY, 32'h4);
		// equal to pick-up stays quiet, one step above starts
		pn(16'h0064);
		tk(5);
		chk(condition, `UBP_COND_NORMAL);
		pn(16'h0065);
		wc(`UBP_COND_START, 5);
		wc(`UBP_COND_TRIP, 6);
		chk((k + TC / 2) / TC, 4);
		rc(`UBP_REG_MSET, 32'h65);
		rc(`UBP_REG_RATIO, 32'h3F2);
		rc(`UBP_REG_EXPECT, 32'h4);
		rc(`UBP_REG_REC_ANG, 32'h33331111);
		rc(`UBP_REG_REC_ZERO, 32'h22220005);
		// release band: 97 holds, 96 drops
		pn(16'h0061);
		tk(5);
		chk(condition, `UBP_COND_TRIP);
		pn(16'h0060);
		wc(`UBP_COND_NORMAL, 5);
		// block ahead of pick-up
		fe.set_blk(1'b1);
		tk(1);
		pn(16'h0065);
		wc(`UBP_COND_BLOCKED, 5);
		chk(start_out, 1'b0);
		rc(`UBP_REG_STATUS, 32'hF);
		pn(16'h0060);
		fe.set_blk(1'b0);
		tk(5);
		// block arriving after start, long delay
		wr(`UBP_REG_DELAY, 32'h28);
		pn(16'h0065);
		wc(`UBP_COND_START, 5);
		fe.set_blk(1'b1);
		wc(`UBP_COND_BLOCKED, 5);
		chk(trip_out, 1'b0);
		pn(16'h0060);
		fe.set_blk(1'b0);
		tk(5);
		// instant operation
		wr(`UBP_REG_CTRL, 32'h0);
		pn(16'h0065);
		wc(`UBP_COND_TRIP, 5);
		chk(start_out, 1'b1);
		pn(16'h0060);
		tk(5);
		// ratio mode: 10.1 percent is quiet, 30 percent starts
		wr(`UBP_REG_CTRL, 32'h11);
		pn(16'h0065);
		tk(6);
		chk(condition, `UBP_COND_NORMAL);
		fe.put(16'h0064, 16'h001E, 16'h0064, 16'h0064);
		wc(`UBP_COND_START, 6);
		fe.put(16'h0064, 16'h001E, 16'h0064, 16'h0005);
		wc(`UBP_COND_NORMAL, 6);
		fe.put(16'h0000, 16'h001E, 16'h0064, 16'h0064);
		tk(6);
		chk(condition, `UBP_COND_NORMAL);
		rc(`UBP_REG_RATIO, 32'h0);
		// second group with a higher pick-up, switched live
		wr(`UBP_REG_GSEL, 32'h1);
		wr(`UBP_REG_NEGSET, 32'hC8);
		wr(`UBP_REG_CTRL, 32'h50);
		pn(16'h0096);
		tk(5);
		chk(condition, `UBP_COND_NORMAL);
		wr(`UBP_REG_CTRL, 32'h10);
		wc(`UBP_COND_START, 5);
		pn(16'h0060);
		tk(5);
		// quadratic curve: 6300 / (110^2 - 100^2) gives three ticks
		wr(`UBP_REG_KMULT, 32'h189C);
		wr(`UBP_REG_CTRL, 32'h20);
		pn(16'h006E);
		wc(`UBP_COND_START, 5);
		rc(`UBP_REG_REMAIN, 32'h3);
		rc(`UBP_REG_EXPECT, 32'h3);
		wc(`UBP_COND_TRIP, 5);
		chk((k + TC / 2) / TC, 3);
		pn(16'h0060);
		tk(5);
		// forcing each status, then the field without enable
		for (int f = 0; f < 4; f++) begin
			wr(`UBP_REG_CTRL, 32'h18 | 32'(f << 1));
			repeat (3) @(posedge mclk);
			#1;
			chk(condition, f);
		end
		wr(`UBP_REG_CTRL, 32'h16);
		repeat (3) @(posedge mclk);
		#1;
		chk(condition, `UBP_COND_NORMAL);
		finish_test();
	end
endmodule // ubp_stage_test
